// File: bench/mem_model.sv
// Memory partner model answering opcode fetches, optionally slowly
`timescale 1ns/1ns
module mem_model
#(
	parameter int WAIT_CYC = 6
)
(
	input  wire logic        mclk,
	input  wire logic        slow,
	input  wire logic [15:0] addr_out,
	input  wire logic [15:0] addr_oe,
	input  wire logic        memory_request_n,
	input  wire logic        read_n,
	output logic      [7:0]  data_in,
	output logic             wait_n
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_byte = 8'h00;
	int         sel_cnt = 0;
	logic       sel;
	assign sel = !memory_request_n && !read_n && (addr_oe == 16'hFFFF);
	// Unselected bus shows a toggling value so a stale byte cannot pass
	assign data_in = sel ? mem[addr_out] : ~last_byte;
	assign wait_n = !(slow && sel_cnt < WAIT_CYC);
	always @(posedge mclk)
	begin
		sel_cnt <= sel ? sel_cnt + 1 : 0;
		last_byte <= data_in;
	end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the bus and reset controller
`timescale 1ns/1ns
`include "cpu_bus_map.svh"
module testbench;
	typedef struct {logic [7:0] op; logic ie; logic [1:0] im;} row_t;
	row_t rows [11] = '{'{`OP_NOP, 1'b0, 2'h0}, '{`OP_EI, 1'b0, 2'h0},
		'{`OP_PREFIX_ED, 1'b1, 2'h0}, '{`OP_IM2, 1'b1, 2'h0}, '{`OP_PREFIX_ED, 1'b1, 2'h2},
		'{`OP_IM0, 1'b1, 2'h2}, '{`OP_PREFIX_ED, 1'b1, 2'h0}, '{`OP_IM1, 1'b1, 2'h0},
		'{`OP_DI, 1'b1, 2'h1}, '{`OP_EI, 1'b0, 2'h1}, '{`OP_NOP, 1'b1, 2'h1}};
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        reset_pin_n = 1'b1;
	logic        nmi_n = 1'b1;
	logic        int_n = 1'b1;
	logic        bus_hold_request_n = 1'b1;
	logic        slow = 1'b0;
	logic        wait_n, data_oe, memory_request_n, io_request_n, read_n, write_n;
	logic        refresh_strobe_n, opcode_fetch_cycle_n, halt_n, bus_hold_ack_n, int_enable;
	logic [7:0]  data_in, data_out, int_page, instruction_register;
	logic [15:0] addr_out, addr_oe;
	logic [1:0]  int_mode;
	int          err_count = 0;
	int          checks = 0;
	int          n, fast_len, slow_len;

	always #50 mclk = ~mclk;

	cpu_bus_reset_control u_dut (.mclk(mclk), .rst(rst), .reset_pin_n(reset_pin_n),
		.wait_n(wait_n), .nmi_n(nmi_n), .int_n(int_n), .bus_hold_request_n(bus_hold_request_n),
		.data_in(data_in), .addr_out(addr_out), .addr_oe(addr_oe), .data_out(data_out),
		.data_oe(data_oe), .memory_request_n(memory_request_n), .io_request_n(io_request_n),
		.read_n(read_n), .write_n(write_n), .refresh_strobe_n(refresh_strobe_n),
		.opcode_fetch_cycle_n(opcode_fetch_cycle_n), .halt_n(halt_n),
		.bus_hold_ack_n(bus_hold_ack_n), .int_enable(int_enable), .int_mode(int_mode),
		.int_page(int_page), .instruction_register(instruction_register));

	mem_model u_mem (.mclk(mclk), .slow(slow), .addr_out(addr_out), .addr_oe(addr_oe),
		.memory_request_n(memory_request_n), .read_n(read_n), .data_in(data_in),
		.wait_n(wait_n));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check_idle();
		check(32'({addr_oe, data_oe}), 32'h0000_0000);
		check(32'({addr_out, data_out}), 32'h00FF_FFFF);
		check(32'({memory_request_n, io_request_n, read_n, write_n, refresh_strobe_n,
			opcode_fetch_cycle_n, halt_n, bus_hold_ack_n}), 32'h0000_00FF);
		check(32'({int_enable, int_mode, int_page}), 32'h0000_0000);
	endtask

	task automatic find_fetch(input logic [15:0] a);
		int k;
		for (k = 0; k < 50 && opcode_fetch_cycle_n !== 1'b0; k++) @(negedge mclk);
		check(32'(addr_out), 32'(a));
		check(32'(addr_oe), 32'h0000_FFFF);
		check(32'({memory_request_n, read_n, opcode_fetch_cycle_n, io_request_n, write_n,
			refresh_strobe_n, bus_hold_ack_n}), 32'h0000_000F);
	endtask

	task automatic refresh_check(input logic [6:0] r, input logic [7:0] op, output int len);
		for (len = 0; len < 50 && refresh_strobe_n !== 1'b0; len++) @(negedge mclk);
		check(32'(addr_out), 32'({9'h000, r}));
		check(32'(instruction_register), 32'(op));
	endtask

	task automatic wait_fetch_at(input logic [15:0] a);
		int k;
		for (k = 0; k < 200 && !(opcode_fetch_cycle_n === 1'b0 && addr_out === a); k++)
			@(negedge mclk);
		check(32'(addr_out), 32'(a));
		check(32'(halt_n), 32'h0000_0001);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		for (int i = 0; i < 65536; i++) u_mem.mem[i] = `OP_NOP;
		foreach (rows[i]) u_mem.mem[i] = rows[i].op;
		u_mem.mem[16'h0020] = `OP_HALT;
		u_mem.mem[16'h0038] = `OP_HALT;
		repeat (16) @(negedge mclk);
		check_idle();
		rst = 1'b0;
		foreach (rows[k])
		begin
			find_fetch(16'(k));
			check(32'({int_enable, int_mode}), 32'({rows[k].ie, rows[k].im}));
			refresh_check(7'(k), rows[k].op, n);
		end
		// Stretched fetch against a plain one
		find_fetch(16'h000B);
		refresh_check(7'h0B, `OP_NOP, fast_len);
		slow = 1'b1;
		find_fetch(16'h000C);
		refresh_check(7'h0C, `OP_NOP, slow_len);
		slow = 1'b0;
		check(32'(slow_len >= fast_len + 4), 32'h0000_0001);
		@(negedge mclk);
		bus_hold_request_n = 1'b0;
		for (n = 0; n < 20 && bus_hold_ack_n !== 1'b0; n++) @(negedge mclk);
		repeat (5) @(negedge mclk);
		check(32'({bus_hold_ack_n, addr_oe, data_oe, memory_request_n, read_n}),
			32'h0000_0003);
		bus_hold_request_n = 1'b1;
		// Request lands two edges late, so the fetch at 000D runs before the hold
		find_fetch(16'h000E);
		refresh_check(7'h0E, `OP_NOP, n);
		for (n = 0; n < 400 && halt_n !== 1'b0; n++) @(negedge mclk);
		repeat (20) @(negedge mclk);
		check(32'(halt_n), 32'h0000_0000);
		int_n = 1'b0;
		wait_fetch_at(16'h0038);
		int_n = 1'b1;
		for (n = 0; n < 200 && halt_n !== 1'b0; n++) @(negedge mclk);
		nmi_n = 1'b0;
		repeat (4) @(negedge mclk);
		nmi_n = 1'b1;
		wait_fetch_at(16'h0066);
		// Pin reset with a maskable request pending that must be refused
		reset_pin_n = 1'b0;
		int_n = 1'b0;
		repeat (4) @(negedge mclk);
		check_idle();
		reset_pin_n = 1'b1;
		find_fetch(16'h0000);
		refresh_check(7'h00, `OP_NOP, n);
		find_fetch(16'h0001);
		refresh_check(7'h01, `OP_EI, n);
		int_n = 1'b1;
		print_verdict();
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge mclk);
		err_count++;
		print_verdict();
	end
endmodule

// File: design/cpu_bus_map.svh
// Constants for the processor bus and reset controller
`ifndef CPU_BUS_MAP_SVH
`define CPU_BUS_MAP_SVH
`define RESET_PC        16'h0000
`define RESET_REG8      8'h00
`define RESET_REG16     16'h0000
`define RESET_IMODE     2'h0
`define REFRESH_BITS    7
`define ADDR_IDLE       16'hFFFF
`define DATA_IDLE       8'hFF
`define OP_HALT         8'h76
`define OP_NOP          8'h00
`define OP_DI           8'hF3
`define OP_EI           8'hFB
`define OP_IM0          8'h46
`define OP_IM1          8'h56
`define OP_IM2          8'h5E
`define OP_PREFIX_ED    8'hED
`define NMI_VECTOR      16'h0066
`define INT_VECTOR      16'h0038
`endif

// File: design/cpu_bus_pkg.sv
// Types shared by the processor bus controller
package cpu_bus_pkg;
	typedef enum logic [2:0] {
		ST_RESET,
		ST_T1,
		ST_T2,
		ST_T3,
		ST_T4,
		ST_BUS_HELD
	} bus_state_t;
endpackage

// File: design/cpu_bus_reset_control.sv
// Bus, reset and request control of an 8-bit processor core
`timescale 1ns/1ns
`include "cpu_bus_map.svh"
module cpu_bus_reset_control
	import cpu_bus_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        reset_pin_n,
	input  wire logic        wait_n,
	input  wire logic        nmi_n,
	input  wire logic        int_n,
	input  wire logic        bus_hold_request_n,
	input  wire logic [7:0]  data_in,
	output logic      [15:0] addr_out,
	output logic      [15:0] addr_oe,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	output logic             memory_request_n,
	output logic             io_request_n,
	output logic             read_n,
	output logic             write_n,
	output logic             refresh_strobe_n,
	output logic             opcode_fetch_cycle_n,
	output logic             halt_n,
	output logic             bus_hold_ack_n,
	output logic             int_enable,
	output logic      [1:0]  int_mode,
	output logic      [7:0]  int_page,
	output logic      [7:0]  instruction_register
);
	////////////////////////////////////////////////////////////////////////
	logic       reset_s;
	logic       wait_s;
	logic       nmi_s;
	logic       int_s;
	logic       bus_hold_request_n_s;
	logic       cpu_reset;
	logic       nmi_prev_reg;
	logic       nmi_pending_reg;
	logic       ed_prefix_reg;
	logic       refresh_step;
	logic [7:0] refresh_reg;
	logic [15:0] program_counter;
	logic [15:0] program_counter_next;
	bus_state_t state_reg;
	bus_state_t state_next;
	// Register file: main, alternate and index sets
	logic [7:0]  gp_reg [0:7];
	logic [7:0]  alt_reg [0:7];
	logic [15:0] index_reg_x;
	logic [15:0] index_reg_y;

	pin_sync #(.WIDTH(5), .INIT(5'h1F)) u_sync
	(
		.mclk     (mclk),
		.rst      (rst),
		.pin_in   ({reset_pin_n, wait_n, nmi_n, int_n, bus_hold_request_n}),
		.sync_out ({reset_s, wait_s, nmi_s, int_s, bus_hold_request_n_s})
	);

	assign cpu_reset = rst | ~reset_s;

	assign refresh_step = (state_reg == ST_T4);

	refresh_counter u_refresh
	(
		.mclk        (mclk),
		.rst         (cpu_reset),
		.step        (refresh_step),
		.refresh_reg (refresh_reg)
	);

	// Maskable request is vectored in mode one only; other modes leave it waiting
	function automatic logic int_taken(input logic en, input logic req_n, input logic [1:0] mode);
		int_taken = en && !req_n && mode == 2'h1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus state sequencing
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET:
				state_next = ST_T1;
			ST_T1:
				state_next = ST_T2;
			ST_T2:
				if (wait_s)
					state_next = ST_T3;
			ST_T3:
				state_next = ST_T4;
			ST_T4:
				if (!bus_hold_request_n_s)
					state_next = ST_BUS_HELD;
				else
					state_next = ST_T1;
			ST_BUS_HELD:
				if (bus_hold_request_n_s)
					state_next = ST_T1;
			default:
				state_next = ST_RESET;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (cpu_reset)
			state_reg <= ST_RESET;
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Program counter and interrupt entry
	always_comb
	begin
		program_counter_next = program_counter;
		if (state_reg == ST_T4)
		begin
			if (nmi_pending_reg)
				program_counter_next = `NMI_VECTOR;
			else if (int_taken(int_enable, int_s, int_mode))
				program_counter_next = `INT_VECTOR;
			else if (!halt_n)
				program_counter_next = program_counter;
			else
				program_counter_next = 16'(program_counter + 16'h0001);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (cpu_reset)
			program_counter <= `RESET_PC;
		else
			program_counter <= program_counter_next;
	end

	// Edge detect on the synchronised copy only
	always_ff @(posedge mclk)
	begin
		if (cpu_reset)
		begin
			nmi_prev_reg    <= 1'b1;
			nmi_pending_reg <= 1'b0;
		end
		else
		begin
			nmi_prev_reg <= nmi_s;
			if (nmi_prev_reg && !nmi_s)
				nmi_pending_reg <= 1'b1;
			else if (state_reg == ST_T4)
				nmi_pending_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Opcode capture and the few decoded controls
	always_ff @(posedge mclk)
	begin
		if (cpu_reset)
			instruction_register <= `OP_NOP;
		else if (state_reg == ST_T2 && wait_s)
			instruction_register <= data_in;
	end

	always_ff @(posedge mclk)
	begin
		if (cpu_reset)
		begin
			int_enable    <= 1'b0;
			int_mode      <= `RESET_IMODE;
			ed_prefix_reg <= 1'b0;
		end
		else if (state_reg == ST_T4)
		begin
			ed_prefix_reg <= (instruction_register == `OP_PREFIX_ED);
			if (nmi_pending_reg || int_taken(int_enable, int_s, int_mode))
				int_enable <= 1'b0;
			else if (instruction_register == `OP_EI)
				int_enable <= 1'b1;
			else if (instruction_register == `OP_DI)
				int_enable <= 1'b0;
			if (ed_prefix_reg && instruction_register == `OP_IM0)
				int_mode <= 2'h0;
			else if (ed_prefix_reg && instruction_register == `OP_IM1)
				int_mode <= 2'h1;
			else if (ed_prefix_reg && instruction_register == `OP_IM2)
				int_mode <= 2'h2;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (cpu_reset)
			halt_n <= 1'b1;
		else if (state_reg == ST_T4)
		begin
			if (nmi_pending_reg || int_taken(int_enable, int_s, int_mode))
				halt_n <= 1'b1;
			else if (instruction_register == `OP_HALT && !ed_prefix_reg)
				halt_n <= 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (cpu_reset)
		begin
			for (int i = 0; i < 8; i++)
			begin
				gp_reg[i]  <= `RESET_REG8;
				alt_reg[i] <= `RESET_REG8;
			end
			index_reg_x <= `RESET_REG16;
			index_reg_y <= `RESET_REG16;
			int_page    <= `RESET_REG8;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive; every output registered
	always_ff @(posedge mclk)
	begin
		if (cpu_reset)
		begin
			addr_out <= `ADDR_IDLE;
			addr_oe  <= 16'h0000;
			data_out <= `DATA_IDLE;
			data_oe  <= 1'b0;
			memory_request_n     <= 1'b1;
			io_request_n         <= 1'b1;
			read_n               <= 1'b1;
			write_n              <= 1'b1;
			refresh_strobe_n     <= 1'b1;
			opcode_fetch_cycle_n <= 1'b1;
			bus_hold_ack_n       <= 1'b1;
		end
		else
		begin
			data_out <= `DATA_IDLE;
			data_oe  <= 1'b0;
			io_request_n <= 1'b1;
			write_n      <= 1'b1;
			case (state_next)
				ST_T1, ST_T2:
				begin
					addr_out <= program_counter_next;
					addr_oe  <= 16'hFFFF;
					memory_request_n     <= 1'b0;
					read_n               <= 1'b0;
					opcode_fetch_cycle_n <= 1'b0;
					refresh_strobe_n     <= 1'b1;
					bus_hold_ack_n       <= 1'b1;
				end
				ST_T3, ST_T4:
				begin
					addr_out <= {int_page, 1'b0, refresh_reg[`REFRESH_BITS-1:0]};
					addr_oe  <= 16'hFFFF;
					refresh_strobe_n     <= 1'b0;
					memory_request_n     <= (state_next == ST_T3) ? 1'b1 : 1'b0;
					read_n               <= 1'b1;
					opcode_fetch_cycle_n <= 1'b1;
					bus_hold_ack_n       <= 1'b1;
				end
				ST_BUS_HELD:
				begin
					addr_out <= `ADDR_IDLE;
					addr_oe  <= 16'h0000;
					memory_request_n     <= 1'b1;
					read_n               <= 1'b1;
					refresh_strobe_n     <= 1'b1;
					opcode_fetch_cycle_n <= 1'b1;
					bus_hold_ack_n       <= 1'b0;
				end
				default:
				begin
					addr_out <= `ADDR_IDLE;
					addr_oe  <= 16'h0000;
					memory_request_n     <= 1'b1;
					read_n               <= 1'b1;
					refresh_strobe_n     <= 1'b1;
					opcode_fetch_cycle_n <= 1'b1;
					bus_hold_ack_n       <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_reset_pins_idle: assert property (@(posedge mclk)
		$past(cpu_reset) |-> memory_request_n && read_n && halt_n && bus_hold_ack_n)
		else $error("control outputs active during reset");

	chk_reset_bus_float: assert property (@(posedge mclk)
		$past(cpu_reset) |-> addr_oe == 16'h0000 && !data_oe)
		else $error("bus driven during reset");

	chk_first_fetch_zero: assert property (@(posedge mclk)
		$past(cpu_reset) && !cpu_reset |=> !opcode_fetch_cycle_n && addr_out == 16'h0000)
		else $error("first fetch not from zero");

	chk_reset_int_state: assert property (@(posedge mclk)
		$past(cpu_reset) |-> !int_enable && int_mode == 2'h0)
		else $error("interrupt state not cleared");

	chk_refresh_address: assert property (@(posedge mclk) disable iff (cpu_reset)
		!refresh_strobe_n |-> addr_out[6:0] == refresh_reg[6:0] && addr_out[7] == 1'b0)
		else $error("refresh address mismatch");

	chk_wait_stall: assert property (@(posedge mclk) disable iff (cpu_reset)
		state_reg == ST_T2 && !wait_s |=> state_reg == ST_T2)
		else $error("advanced past wait");

	chk_fetch_order: assert property (@(posedge mclk) disable iff (cpu_reset)
		state_reg == ST_T2 && wait_s |=> !refresh_strobe_n && opcode_fetch_cycle_n)
		else $error("refresh did not follow fetch");

	chk_bus_ack: assert property (@(posedge mclk) disable iff (cpu_reset)
		!bus_hold_ack_n |-> addr_oe == 16'h0000 && memory_request_n)
		else $error("acknowledge while driving bus");

	chk_halt_pc_hold: assert property (@(posedge mclk) disable iff (cpu_reset)
		!halt_n && !nmi_pending_reg && int_s |=> program_counter == $past(program_counter))
		else $error("execution continued while halted");
endmodule

// File: design/pin_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
)
(
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			meta_reg <= INIT;
			sync_out <= INIT;
		end
		else
		begin
			meta_reg <= pin_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// File: design/refresh_counter.sv
// Refresh address counter: low seven bits count, top bit held
`timescale 1ns/1ns
`include "cpu_bus_map.svh"
module refresh_counter
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       step,
	output logic      [7:0] refresh_reg
);
	logic [7:0] refresh_next;

	always_comb
	begin
		refresh_next = refresh_reg;
		if (step)
			refresh_next = {refresh_reg[7], 7'(refresh_reg[6:0] + 7'h01)};
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			refresh_reg <= `RESET_REG8;
		else
			refresh_reg <= refresh_next;
	end
endmodule
